/* File: hdl/clcb_defs.svh */
// register map, field positions and reset values of the closed-loop config bank
`ifndef CLCB_DEFS_SVH
`define CLCB_DEFS_SVH

// ----------------------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------------------
`define CLCB_IDX_PULSE 8'h88
`define CLCB_IDX_STOP 8'h8A
`define CLCB_IDX_CGAIN 8'h8C
`define CLCB_IDX_SGAIN 8'h8E
`define CLCB_IDX_STATUS 8'h90
`define CLCB_ADDR_PULSE 12'h220
`define CLCB_ADDR_STOP 12'h228
`define CLCB_ADDR_CGAIN 12'h230
`define CLCB_ADDR_SGAIN 12'h238
`define CLCB_ADDR_STATUS 12'h240

// ----------------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------------
`define CLCB_RST_PULSE 32'h00000000
`define CLCB_RST_STOP 32'h00000000
`define CLCB_RST_CGAIN 32'h00000000
`define CLCB_RST_SGAIN 32'h00000000
`define CLCB_MASK_PULSE 32'h00000FFE
`define CLCB_MASK_STOP 32'h7FFFFFFF
`define CLCB_MASK_CGAIN 32'h7FFFFFFF
`define CLCB_MASK_SGAIN 32'h7FFFFFFF

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CLCB_DIV_MSB 11
`define CLCB_DIV_LSB 8
`define CLCB_PMODE_BIT 7
`define CLCB_THR_MSB 6
`define CLCB_THR_LSB 4
`define CLCB_SURGE_BIT 3
`define CLCB_DTC_BIT 2
`define CLCB_SPDDIS_BIT 1
`define CLCB_STOP_MSB 30
`define CLCB_STOP_LSB 28
`define CLCB_BRK_MSB 27
`define CLCB_BRK_LSB 24
`define CLCB_SPIN_MSB 23
`define CLCB_SPIN_LSB 20
`define CLCB_CLAMP_MSB 19
`define CLCB_CLAMP_LSB 16
`define CLCB_RES_MSB 15
`define CLCB_RES_LSB 8
`define CLCB_IND_MSB 7
`define CLCB_IND_LSB 0
`define CLCB_KE_MSB 30
`define CLCB_KE_LSB 23
`define CLCB_CKP_MSB 22
`define CLCB_CKP_LSB 13
`define CLCB_CKI_MSB 12
`define CLCB_CKI_LSB 3
`define CLCB_SKPH_MSB 2
`define CLCB_SKPH_LSB 0
`define CLCB_SKPL_MSB 30
`define CLCB_SKPL_LSB 24
`define CLCB_SKI_MSB 23
`define CLCB_SKI_LSB 14
`define CLCB_MAXS_MSB 13
`define CLCB_MAXS_LSB 0

// ----------------------------------------------------------------------------
// stop method codes
// ----------------------------------------------------------------------------
`define CLCB_STOP_HIZ 3'h0
`define CLCB_STOP_LSBRAKE 3'h2
`define CLCB_STOP_SPIN 3'h4

`endif

/* File: hdl/clcb_pkg.sv */
// types shared by the closed-loop config bank
package clcb_pkg;

  // --------------------------------------------------------------------------
  // raw configuration fields
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] speed_pulse_divider;
    logic speed_pulse_mode;
    logic [2:0] pulse_backemf_threshold;
    logic surge_guard_enable;
    logic deadtime_comp_enable;
    logic speed_regulator_disable;
    logic [2:0] stop_method;
    logic [3:0] stop_clamp_duration;
    logic [3:0] spin_down_speed_limit;
    logic [3:0] clamp_speed_limit;
    logic [7:0] phase_resistance_code;
    logic [7:0] phase_inductance_code;
    logic [7:0] backemf_constant_code;
    logic [9:0] current_prop_gain;
    logic [9:0] current_integral_gain;
    logic [9:0] speed_prop_gain;
    logic [9:0] speed_integral_gain;
    logic [13:0] max_speed;
  } clcb_cfg_s;

  // --------------------------------------------------------------------------
  // decoded settings
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] div_ratio;
    logic [4:0] back_emf_thr_mv;
    logic thr_reserved;
    logic stop_reserved;
    logic [13:0] brake_ms;
    logic [9:0] spin_pct_x10;
    logic [9:0] clamp_pct_x10;
    logic current_gain_auto;
    logic speed_loop_run;
  } clcb_dec_s;

endpackage : clcb_pkg

/* File: hdl/clcb_bank.sv */
// closed-loop configuration register bank with speed-pulse divider
`timescale 1ns/100ps
`include "clcb_defs.svh"

module clcb_bank
  import clcb_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // motor-side inputs from the control core
  input wire logic MOTOR_DRIVEN,
  input wire logic RAW_PULSE,
  input wire logic [7:0] BACK_EMF_MV,
  // settings and speed pulse
  output clcb_cfg_s CFG,
  output clcb_dec_s DEC,
  output logic SPEED_PULSE_OUT
);

  // --------------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------------
  logic [31:0] reg_pulse;
  logic [31:0] reg_stop;
  logic [31:0] reg_cgain;
  logic [31:0] reg_sgain;
  logic [3:0] pulse_cnt;
  logic raw_q;
  logic expired;
  logic pulse_active;
  logic back_emf_below;
  logic wr_access;
  logic [31:0] status_word;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction : merge

  function automatic logic addr_hit(input logic [11:0] a);
    return (a == `CLCB_ADDR_PULSE) || (a == `CLCB_ADDR_STOP) || (a == `CLCB_ADDR_CGAIN) ||
           (a == `CLCB_ADDR_SGAIN) || (a == `CLCB_ADDR_STATUS);
  endfunction : addr_hit

  // percent of max speed in tenths, shared by spin-down and clamp limits
  function automatic logic [9:0] pct_x10(input logic [3:0] c);
    logic [9:0] p;
    p = 10'h000;
    unique case (c)
      4'h0: p = 10'h3E8;
      4'h1: p = 10'h384;
      4'h2: p = 10'h320;
      4'h3: p = 10'h2BC;
      4'h4: p = 10'h258;
      4'h5: p = 10'h1F4;
      4'h6: p = 10'h1C2;
      4'h7: p = 10'h190;
      4'h8: p = 10'h15E;
      4'h9: p = 10'h12C;
      4'hA: p = 10'h0FA;
      4'hB: p = 10'h0C8;
      4'hC: p = 10'h096;
      4'hD: p = 10'h064;
      4'hE: p = 10'h032;
      4'hF: p = 10'h019;
    endcase
    return p;
  endfunction : pct_x10

  // --------------------------------------------------------------------------
  // apb slave: zero wait states, read data captured in the setup cycle
  // --------------------------------------------------------------------------
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_hit(PADDR);
  assign wr_access = PSEL && PENABLE && PWRITE;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        `CLCB_ADDR_PULSE: PRDATA <= reg_pulse & `CLCB_MASK_PULSE;
        `CLCB_ADDR_STOP: PRDATA <= reg_stop & `CLCB_MASK_STOP;
        `CLCB_ADDR_CGAIN: PRDATA <= reg_cgain & `CLCB_MASK_CGAIN;
        `CLCB_ADDR_SGAIN: PRDATA <= reg_sgain & `CLCB_MASK_SGAIN;
        `CLCB_ADDR_STATUS: PRDATA <= status_word;
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end

  // writes land only in the access cycle; masks drop reserved bits
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      reg_pulse <= `CLCB_RST_PULSE;
      reg_stop <= `CLCB_RST_STOP;
      reg_cgain <= `CLCB_RST_CGAIN;
      reg_sgain <= `CLCB_RST_SGAIN;
    end else if (wr_access) begin
      if (PADDR == `CLCB_ADDR_PULSE) begin
        reg_pulse <= merge(reg_pulse, PWDATA, PSTRB, `CLCB_MASK_PULSE);
      end
      if (PADDR == `CLCB_ADDR_STOP) begin
        reg_stop <= merge(reg_stop, PWDATA, PSTRB, `CLCB_MASK_STOP);
      end
      if (PADDR == `CLCB_ADDR_CGAIN) begin
        reg_cgain <= merge(reg_cgain, PWDATA, PSTRB, `CLCB_MASK_CGAIN);
      end
      if (PADDR == `CLCB_ADDR_SGAIN) begin
        reg_sgain <= merge(reg_sgain, PWDATA, PSTRB, `CLCB_MASK_SGAIN);
      end
    end
  end

  // --------------------------------------------------------------------------
  // raw field view
  // --------------------------------------------------------------------------
  assign CFG.speed_pulse_divider = reg_pulse[`CLCB_DIV_MSB:`CLCB_DIV_LSB];
  assign CFG.speed_pulse_mode = reg_pulse[`CLCB_PMODE_BIT];
  assign CFG.pulse_backemf_threshold = reg_pulse[`CLCB_THR_MSB:`CLCB_THR_LSB];
  assign CFG.surge_guard_enable = reg_pulse[`CLCB_SURGE_BIT];
  assign CFG.deadtime_comp_enable = reg_pulse[`CLCB_DTC_BIT];
  assign CFG.speed_regulator_disable = reg_pulse[`CLCB_SPDDIS_BIT];
  assign CFG.stop_method = reg_stop[`CLCB_STOP_MSB:`CLCB_STOP_LSB];
  assign CFG.stop_clamp_duration = reg_stop[`CLCB_BRK_MSB:`CLCB_BRK_LSB];
  assign CFG.spin_down_speed_limit = reg_stop[`CLCB_SPIN_MSB:`CLCB_SPIN_LSB];
  assign CFG.clamp_speed_limit = reg_stop[`CLCB_CLAMP_MSB:`CLCB_CLAMP_LSB];
  assign CFG.phase_resistance_code = reg_stop[`CLCB_RES_MSB:`CLCB_RES_LSB];
  assign CFG.phase_inductance_code = reg_stop[`CLCB_IND_MSB:`CLCB_IND_LSB];
  assign CFG.backemf_constant_code = reg_cgain[`CLCB_KE_MSB:`CLCB_KE_LSB];
  assign CFG.current_prop_gain = reg_cgain[`CLCB_CKP_MSB:`CLCB_CKP_LSB];
  assign CFG.current_integral_gain = reg_cgain[`CLCB_CKI_MSB:`CLCB_CKI_LSB];
  // the speed gain straddles two registers: high bits first
  assign CFG.speed_prop_gain = {reg_cgain[`CLCB_SKPH_MSB:`CLCB_SKPH_LSB],
                                reg_sgain[`CLCB_SKPL_MSB:`CLCB_SKPL_LSB]};
  assign CFG.speed_integral_gain = reg_sgain[`CLCB_SKI_MSB:`CLCB_SKI_LSB];
  assign CFG.max_speed = reg_sgain[`CLCB_MAXS_MSB:`CLCB_MAXS_LSB];

  // --------------------------------------------------------------------------
  // decoded settings, registered one cycle behind the fields
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DEC <= '0;
    end else begin
      DEC.div_ratio <= (CFG.speed_pulse_divider < 4'h2) ? 4'h1 : CFG.speed_pulse_divider;
      // reserved threshold codes are undefined; they fall back to the widest window
      unique case (CFG.pulse_backemf_threshold)
        3'h0: DEC.back_emf_thr_mv <= 5'h01;
        3'h1: DEC.back_emf_thr_mv <= 5'h02;
        3'h2: DEC.back_emf_thr_mv <= 5'h05;
        3'h3: DEC.back_emf_thr_mv <= 5'h0A;
        3'h4: DEC.back_emf_thr_mv <= 5'h14;
        default: DEC.back_emf_thr_mv <= 5'h1E;
      endcase
      DEC.thr_reserved <= CFG.pulse_backemf_threshold > 3'h5;
      DEC.stop_reserved <= (CFG.stop_method != `CLCB_STOP_HIZ) &&
                           (CFG.stop_method != `CLCB_STOP_LSBRAKE) &&
                           (CFG.stop_method != `CLCB_STOP_SPIN);
      unique case (CFG.stop_clamp_duration)
        4'h5: DEC.brake_ms <= 14'h0005;
        4'h6: DEC.brake_ms <= 14'h000A;
        4'h7: DEC.brake_ms <= 14'h0032;
        4'h8: DEC.brake_ms <= 14'h0064;
        4'h9: DEC.brake_ms <= 14'h00FA;
        4'hA: DEC.brake_ms <= 14'h01F4;
        4'hB: DEC.brake_ms <= 14'h03E8;
        4'hC: DEC.brake_ms <= 14'h09C4;
        4'hD: DEC.brake_ms <= 14'h1388;
        4'hE: DEC.brake_ms <= 14'h2710;
        4'hF: DEC.brake_ms <= 14'h3A98;
        default: DEC.brake_ms <= 14'h0001;
      endcase
      DEC.spin_pct_x10 <= pct_x10(CFG.spin_down_speed_limit);
      DEC.clamp_pct_x10 <= pct_x10(CFG.clamp_speed_limit);
      DEC.current_gain_auto <= CFG.current_prop_gain == 10'h000;
      DEC.speed_loop_run <= !CFG.speed_regulator_disable;
    end
  end

  // --------------------------------------------------------------------------
  // speed pulse output
  // --------------------------------------------------------------------------
  assign back_emf_below = BACK_EMF_MV < {3'h0, DEC.back_emf_thr_mv};
  assign pulse_active = MOTOR_DRIVEN && !(CFG.speed_pulse_mode && expired);

  // in pulse mode 1, once back-EMF has fallen the output stays off until the drive restarts
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      expired <= 1'b0;
    end else if (!MOTOR_DRIVEN) begin
      expired <= 1'b0;
    end else if (CFG.speed_pulse_mode && back_emf_below) begin
      expired <= 1'b1;
    end
  end

  // each raw edge counts; divide-by-one reproduces the raw wave
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      raw_q <= 1'b0;
      pulse_cnt <= 4'h0;
      SPEED_PULSE_OUT <= 1'b0;
    end else begin
      raw_q <= RAW_PULSE;
      if (!pulse_active) begin
        pulse_cnt <= 4'h0;
        SPEED_PULSE_OUT <= 1'b0;
      end else if (RAW_PULSE ^ raw_q) begin
        if (pulse_cnt >= DEC.div_ratio - 4'h1) begin
          pulse_cnt <= 4'h0;
          SPEED_PULSE_OUT <= !SPEED_PULSE_OUT;
        end else begin
          pulse_cnt <= pulse_cnt + 4'h1;
        end
      end
    end
  end

  assign status_word = {27'h0000000, DEC.stop_reserved, DEC.thr_reserved, expired,
                        pulse_active, SPEED_PULSE_OUT};

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_write(logic [11:0] a, int lane);
    PSEL && PENABLE && PWRITE && PADDR == a && PSTRB[lane];
  endsequence

  sequence s_expire;
    CFG.speed_pulse_mode && MOTOR_DRIVEN && back_emf_below ##1 MOTOR_DRIVEN;
  endsequence

  sequence s_write_all(logic [11:0] a);
    PSEL && PENABLE && PWRITE && PADDR == a && PSTRB == 4'hF;
  endsequence

  a_div_ratio_map: assert property (ARST_N |=> DEC.div_ratio ==
    (($past(CFG.speed_pulse_divider) < 4'h2) ? 4'h1 : $past(CFG.speed_pulse_divider)))
    else $error("divider ratio decode wrong");

  a_pulse_cut_off: assert property (s_expire |=> !SPEED_PULSE_OUT)
    else $error("speed pulse active after back-emf fell");

  a_pulse_idle_low: assert property (!MOTOR_DRIVEN |=> !SPEED_PULSE_OUT)
    else $error("speed pulse active while motor not driven");

  a_thr_ten_mv: assert property (CFG.pulse_backemf_threshold == 3'h3
                                 |=> DEC.back_emf_thr_mv == 5'h0A)
    else $error("threshold code 3 not 10 mV");

  a_surge_bit_write: assert property (s_write(`CLCB_ADDR_PULSE, 0)
                                      |=> CFG.surge_guard_enable == $past(PWDATA[3]))
    else $error("surge guard enable not written");

  a_deadtime_write: assert property (s_write(`CLCB_ADDR_PULSE, 0)
                                     |=> CFG.deadtime_comp_enable == $past(PWDATA[2]))
    else $error("deadtime compensation enable not written");

  a_speed_loop_pol: assert property (CFG.speed_regulator_disable |=> !DEC.speed_loop_run)
    else $error("speed loop runs while disabled");

  a_stop_reserved: assert property (CFG.stop_method == 3'h3 |=> DEC.stop_reserved)
    else $error("reserved stop code not flagged");

  a_brake_short: assert property (ARST_N && CFG.stop_clamp_duration <= 4'h4
                                  |=> DEC.brake_ms == 14'h0001)
    else $error("short brake codes not 1 ms");

  a_pct_lowest: assert property (CFG.clamp_speed_limit == 4'hF
                                 |=> DEC.clamp_pct_x10 == 10'h019)
    else $error("clamp code F not 2.5 percent");

  a_gain_auto: assert property (s_write(`CLCB_ADDR_CGAIN, 2) ##1 CFG.current_prop_gain == 10'h000
                                |=> DEC.current_gain_auto)
    else $error("zero current gain not auto");

  a_spd_gain_join: assert property (s_write(`CLCB_ADDR_SGAIN, 3)
                                    |=> CFG.speed_prop_gain[6:0] == $past(PWDATA[30:24]))
    else $error("speed gain low bits not joined");

  a_reserved_read: assert property (PSEL && PENABLE && !PWRITE |-> PRDATA[31] == 1'b0)
    else $error("reserved top bit reads nonzero");

  a_ke_code_write: assert property (s_write_all(`CLCB_ADDR_CGAIN)
                                    |=> CFG.backemf_constant_code == $past(PWDATA[30:23]))
    else $error("back-emf constant code not written");

  a_cur_kp_write: assert property (s_write_all(`CLCB_ADDR_CGAIN)
                                   |=> CFG.current_prop_gain == $past(PWDATA[22:13]))
    else $error("current proportional gain not written");

  a_cur_ki_write: assert property (s_write_all(`CLCB_ADDR_CGAIN)
                                   |=> CFG.current_integral_gain == $past(PWDATA[12:3]))
    else $error("current integral gain not written");

  a_spd_gain_high: assert property (s_write(`CLCB_ADDR_CGAIN, 0)
                                    |=> CFG.speed_prop_gain[9:7] == $past(PWDATA[2:0]))
    else $error("speed gain high bits not written");

  a_max_speed_write: assert property (s_write_all(`CLCB_ADDR_SGAIN)
                                      |=> CFG.max_speed == $past(PWDATA[13:0]))
    else $error("maximum speed not written");

  a_res_code_write: assert property (s_write(`CLCB_ADDR_STOP, 1)
                                     |=> CFG.phase_resistance_code == $past(PWDATA[15:8]))
    else $error("phase resistance code not written");

  a_ind_code_write: assert property (s_write(`CLCB_ADDR_STOP, 0)
                                     |=> CFG.phase_inductance_code == $past(PWDATA[7:0]))
    else $error("phase inductance code not written");

  a_spin_pct_map: assert property (ARST_N && CFG.spin_down_speed_limit == 4'h6
                                   |=> DEC.spin_pct_x10 == 10'h1C2)
    else $error("spin-down code 6 not 45 percent");

  a_thr_reserved: assert property (ARST_N && CFG.pulse_backemf_threshold == 3'h7
                                   |=> DEC.thr_reserved && DEC.back_emf_thr_mv == 5'h1E)
    else $error("reserved threshold code not flagged");

  a_brake_long: assert property (ARST_N && CFG.stop_clamp_duration == 4'hF
                                 |=> DEC.brake_ms == 14'h3A98)
    else $error("brake code F not 15000 ms");

  a_expired_clear: assert property (!MOTOR_DRIVEN |=> !expired)
    else $error("cut-off latch held while motor not driven");

  a_err_no_write: assert property (PSEL && PENABLE && PWRITE && PSLVERR
                                   |=> $stable(reg_pulse) && $stable(reg_stop) &&
                                       $stable(reg_cgain) && $stable(reg_sgain))
    else $error("refused write changed a register");

  a_read_unmapped: assert property (PSEL && !PENABLE && !PWRITE && !addr_hit(PADDR)
                                    |=> PRDATA == 32'h00000000)
    else $error("unmapped read not zero");

endmodule : clcb_bank

/* File: testbench/test_closed_loop_config_bank.sv */
// self-checking bench for the closed-loop config bank
`timescale 1ns/100ps
`include "clcb_defs.svh"

module test_closed_loop_config_bank
  import clcb_pkg::*;
;
  // ----------------------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, er, drv = 1'b0, raw = 1'b0, pout;
  logic [7:0] emf = 8'h00;
  clcb_cfg_s cfg;
  clcb_dec_s dec;
  int err_count = 0, check_count = 0;
  logic [31:0] mdl [4] = '{32'h0, 32'h0, 32'h0, 32'h0};
  logic [11:0] adr [5] = '{`CLCB_ADDR_PULSE, `CLCB_ADDR_STOP, `CLCB_ADDR_CGAIN,
                           `CLCB_ADDR_SGAIN, `CLCB_ADDR_STATUS};
  logic [31:0] msk [4] = '{`CLCB_MASK_PULSE, `CLCB_MASK_STOP, `CLCB_MASK_CGAIN,
                           `CLCB_MASK_SGAIN};
  int thr_tab [8] = '{1, 2, 5, 10, 20, 30, 30, 30};
  int brk_tab [16] = '{1, 1, 1, 1, 1, 5, 10, 50, 100, 250, 500, 1000, 2500, 5000, 10000, 15000};
  int pct_tab [16] = '{1000, 900, 800, 700, 600, 500, 450, 400, 350, 300, 250, 200, 150, 100,
                       50, 25};

  always #2.5 clk = ~clk;

  clcb_bank i_clcb_bank (
    .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MOTOR_DRIVEN(drv), .RAW_PULSE(raw), .BACK_EMF_MV(emf),
    .CFG(cfg), .DEC(dec), .SPEED_PULSE_OUT(pout)
  );

  // ----------------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("mismatches %0d, comparisons %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // one apb transfer; waits for pready, never assumes a latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      results();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, adr[i], d, s);
    check(er, 1'b0);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) mdl[i][8*b+:8] = d[8*b+:8];
    end
    mdl[i] = mdl[i] & msk[i];
  endtask : wr

  task automatic rdc(input int i);
    apb(1'b0, adr[i], 32'h0, 4'hF);
    check(rd, mdl[i]);
  endtask : rdc

  // drive raw edges and compare the divided output and status flags
  task automatic pulse_run(input int c, input logic m, input logic [7:0] e, input int k);
    int n;
    logic x;
    n = (c < 2) ? 1 : c;
    x = m && (e < 8'd10);
    wr(0, (c << 8) | (m << 7) | 32'h30, 4'hF);
    emf <= e;
    drv <= 1'b1;
    repeat (3) @(posedge clk);
    for (int j = 0; j < k; j++) begin
      raw <= ~raw;
      repeat (2) @(posedge clk);
    end
    repeat (3) @(posedge clk);
    check(pout, x ? 1'b0 : 1'((k / n) % 2));
    apb(1'b0, adr[4], 32'h0, 4'hF);
    check(rd[2:0], {x, !x, x ? 1'b0 : 1'((k / n) % 2)});
    drv <= 1'b0;
    repeat (3) @(posedge clk);
    check(pout, 1'b0);
  endtask : pulse_run

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    logic [31:0] d, s, g, h;
    void'($urandom(32'h892E));
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check(dec.div_ratio, 1);
    check(dec.brake_ms, 1);
    check(dec.spin_pct_x10, 1000);
    for (int i = 0; i < 4; i++) rdc(i);
    // every code of the divider, stop, brake, spin-down and clamp fields, random data elsewhere
    for (int c = 0; c < 16; c++) begin
      d = $urandom;
      d[11:8] = c[3:0];
      s = $urandom;
      s[30:28] = c[2:0];
      s[27:20] = {c[3:0], c[3:0]};
      s[19:16] = ~c[3:0];
      g = $urandom;
      if (c == 0) g[22:13] = 10'h0;
      h = $urandom;
      wr(0, d, 4'hF);
      wr(1, s, 4'hF);
      wr(2, g, 4'hF);
      wr(3, h, 4'hF);
      repeat (2) @(posedge clk);
      #1;
      check(dec.div_ratio, (c < 2) ? 1 : c);
      check(cfg.speed_pulse_mode, d[7]);
      check(dec.back_emf_thr_mv, thr_tab[d[6:4]]);
      check(dec.thr_reserved, d[6:5] == 2'b11);
      check(cfg.surge_guard_enable, d[3]);
      check(cfg.deadtime_comp_enable, d[2]);
      check(dec.speed_loop_run, !d[1]);
      check(cfg.stop_method, c[2:0]);
      check(dec.stop_reserved, !(c[2:0] inside {3'h0, 3'h2, 3'h4}));
      check(dec.brake_ms, brk_tab[c]);
      check(dec.spin_pct_x10, pct_tab[c]);
      check(dec.clamp_pct_x10, pct_tab[15 - c]);
      check(cfg.phase_resistance_code, s[15:8]);
      check(cfg.phase_inductance_code, s[7:0]);
      check(cfg.backemf_constant_code, g[30:23]);
      check(dec.current_gain_auto, g[22:13] == 10'h0);
      check(cfg.current_integral_gain, g[12:3]);
      check(cfg.speed_prop_gain, {g[2:0], h[30:24]});
      check(cfg.max_speed, h[13:0]);
      check(cfg.speed_integral_gain, h[23:14]);
      for (int i = 0; i < 4; i++) rdc(i);
    end
    // partial byte lanes keep the unselected bytes
    wr(1, $urandom, 4'b0101);
    wr(2, $urandom, 4'b1010);
    rdc(1);
    rdc(2);
    // unmapped and misaligned places answer with an error, status ignores writes
    apb(1'b1, 12'h229, 32'hFFFFFFFF, 4'hF);
    check(er, 1'b1);
    apb(1'b0, 12'h229, 32'h0, 4'hF);
    check({er, rd}, {1'b1, 32'h0});
    apb(1'b1, adr[4], 32'hFFFFFFFF, 4'hF);
    check(er, 1'b0);
    rdc(1);
    // divided speed pulse, both modes, threshold code 3 is 10 mV
    wr(1, 32'h0, 4'hF);
    pulse_run(0, 1'b0, 8'h00, 3);
    pulse_run(1, 1'b0, 8'h00, 5);
    pulse_run(2, 1'b0, 8'h00, 6);
    pulse_run(15, 1'b0, 8'h00, 45);
    pulse_run(3, 1'b1, 8'd200, 9);
    pulse_run(3, 1'b1, 8'd5, 9);
    // a reset in mid-run clears every live register
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    mdl = '{32'h0, 32'h0, 32'h0, 32'h0};
    repeat (2) @(posedge clk);
    check(dec.div_ratio, 1);
    check(cfg.max_speed, 0);
    for (int i = 0; i < 4; i++) rdc(i);
    results();
  end

  // hang guard: the sequence needs well under 20000 cycles
  initial begin
    #100000;
    err_count++;
    results();
  end

endmodule : test_closed_loop_config_bank
